// file: tmr_core.v
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"
// What this block does
// - Only waveform_mode_sel picks counting; out_action_sel picks output actions only.
// - Mode 0 counts up forever, wrapping 0xFF to 0x00.
// - Normal mode sets overflow_flag on the tick count becomes zero; only an ack or a one write clears it.
// - Taking the overflow interrupt clears overflow_flag automatically.
// - Normal mode accepts count_value writes at any time.
// - Mode 2 clears the count when it equals compare_a_value.
// - Clear-on-compare mode sets compare_a_flag at each top, usable as interrupt.
// - Clear-on-compare compare_a_value is direct; written low, count wraps past 0xFF.
// - Clear-on-compare with action 1 toggles wave_out_a per match.
// - Compare output reaches its pin only while its direction is output.
// - Clear-on-compare sets overflow_flag as count passes max to 0x00.
// - Modes 3 and 7 count zero to top; top 0xFF or compare_a_value.
// - Fast PWM clears the count on the tick after it equals top.
// - Fast PWM action 2 clears on match, sets at restart; 3 inverts.
// - Fast PWM sets overflow_flag each time count restarts from top to zero.
// - Fast PWM action 1 never toggles wave_out_a: mode 3 lacks mode_bit_two, mode 7 ignores the A match at top; never B.
// - Fast PWM compare zero gives a spike; compare max holds output constant.
// - Fast PWM compare writes go to a buffer, not the active value.
// - A compare match sets its flag on the following tick.
// - Clock source 0 stops counting; count_value stays software accessible.
// - Writing one to a flag bit clears that flag.
// - PWM compare values update at top; other modes write directly.
module tmr_core (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire timer_tick,
  input wire ovf_int_ack,
  input wire cmpa_int_ack,
  input wire cmpb_int_ack,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg wave_pin_a,
  output reg wave_pin_b,
  output reg wave_oe_a,
  output reg wave_oe_b,
  output reg overflow_flag_out,
  output reg compare_a_flag_out,
  output reg compare_b_flag_out
);
  reg [`TMR_CTRL_W-1:0] ctrl_reg;
  reg [7:0] count_reg;
  reg [7:0] cmpa_buf_reg;
  reg [7:0] cmpb_buf_reg;
  reg [7:0] cmpa_act_reg;
  reg [7:0] cmpb_act_reg;
  reg [2:0] flag_reg;
  reg [1:0] dir_reg;
  reg [1:0] match_reg;
  reg block_reg;
  reg wave_a_reg;
  reg wave_b_reg;
  reg [7:0] count_next;
  reg [2:0] flag_next;
  reg wave_a_next;
  reg wave_b_next;
  wire [1:0] match_now;
  reg [7:0] top_val;
  reg [31:0] rdata_next;
  reg is_ctc;
  reg is_pwm;
  reg at_top;
  wire [2:0] mode;
  wire [1:0] act_a;
  wire [1:0] act_b;
  wire run;
  wire acc;
  wire wr;
  wire [2:0] flag_clr;
  wire tick;
  wire [1:0] set_fire;
  wire wr_ctrl;
  wire wr_count;
  wire wr_cmpa;
  wire wr_cmpb;
  wire wr_flags;
  wire wr_dir;

  // Decoding used for the write strobes and the read mux
  function hit;
    input [11:0] a;
    input [11:0] o;
    begin
      hit = (a == o);
    end
  endfunction

  // Wave action on a compare event; off keeps the state
  function apply_act;
    input [1:0] act;
    input cur;
    begin
      case (act)
        `TMR_ACT_TOGGLE: apply_act = ~cur;
        `TMR_ACT_CLEAR: apply_act = 1'b0;
        `TMR_ACT_SET: apply_act = 1'b1;
        default: apply_act = cur;
      endcase
    end
  endfunction

  // Pin override only for actions that drive the pin in this mode
  function pin_link;
    input [1:0] act;
    input pwm;
    input bit_two;
    begin
      if (act == `TMR_ACT_OFF) begin
        pin_link = 1'b0;
      end else if (pwm && (act == `TMR_ACT_TOGGLE)) begin
        pin_link = bit_two;
      end else begin
        pin_link = 1'b1;
      end
    end
  endfunction

  assign mode = ctrl_reg[`TMR_C_MODE_HI:`TMR_C_MODE_LO];
  assign act_a = ctrl_reg[`TMR_C_ACTA_HI:`TMR_C_ACTA_LO];
  assign act_b = ctrl_reg[`TMR_C_ACTB_HI:`TMR_C_ACTB_LO];
  assign run = (ctrl_reg[`TMR_C_CLK_HI:`TMR_C_CLK_LO] != 3'h0);
  assign tick = run & timer_tick;
  assign acc = psel & penable & ~pready;
  // Writes land on the completing edge, where pready is sampled high
  assign wr = psel & penable & pready & pwrite;
  assign wr_ctrl = wr & hit(paddr, `TMR_A_CTRL);
  assign wr_count = wr & hit(paddr, `TMR_A_COUNT);
  assign wr_cmpa = wr & hit(paddr, `TMR_A_CMPA);
  assign wr_cmpb = wr & hit(paddr, `TMR_A_CMPB);
  assign wr_flags = wr & hit(paddr, `TMR_A_FLAGS);
  assign wr_dir = wr & hit(paddr, `TMR_A_DIR);
  assign flag_clr = wr_flags ? pwdata[2:0] : 3'h0;

  always @* begin
    is_ctc = (mode == `TMR_MODE_CTC);
    is_pwm = (mode == `TMR_MODE_FPWM_FF) || (mode == `TMR_MODE_FPWM_A);
    // Reserved codes fall through to normal counting
    top_val = (mode == `TMR_MODE_FPWM_A) ? cmpa_act_reg : `TMR_MAX;
    at_top = (count_reg == top_val);
  end

  genvar gi;
  // One equality comparator per compare channel
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      wire [7:0] cmp_val;
      assign cmp_val = (gi == 0) ? cmpa_act_reg : cmpb_act_reg;
      assign match_now[gi] = (count_reg == cmp_val);
    end
  endgenerate

  // Compare A clears the count in ctc and in top-at-A pwm
  assign set_fire[0] = match_reg[0];
  assign set_fire[1] = match_reg[1];

  always @* begin
    count_next = count_reg;
    if (tick) begin
      if (is_ctc && match_now[0]) begin
        count_next = `TMR_ZERO;
      end else if (is_pwm && at_top) begin
        count_next = `TMR_ZERO;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
    if (wr_count) begin
      count_next = pwdata[7:0];
    end
  end

  always @* begin
    flag_next = flag_reg;
    if (ovf_int_ack) begin
      flag_next[`TMR_F_OVF] = 1'b0;
    end
    if (cmpa_int_ack) begin
      flag_next[`TMR_F_CMPA] = 1'b0;
    end
    if (cmpb_int_ack) begin
      flag_next[`TMR_F_CMPB] = 1'b0;
    end
    flag_next = flag_next & ~flag_clr;
    if (tick) begin
      // Set beats clear in the same cycle
      if (is_pwm ? at_top : (count_reg == `TMR_MAX)) begin
        flag_next[`TMR_F_OVF] = 1'b1;
      end
      if (set_fire[0]) begin
        flag_next[`TMR_F_CMPA] = 1'b1;
      end
      if (set_fire[1]) begin
        flag_next[`TMR_F_CMPB] = 1'b1;
      end
    end
  end

  always @* begin
    wave_a_next = wave_a_reg;
    wave_b_next = wave_b_reg;
    if (tick) begin
      if (is_pwm) begin
        // Match ignored when compare equals top, so max gives a flat level
        if (match_now[0] && !block_reg && !at_top) begin
          if (act_a == `TMR_ACT_TOGGLE) begin
            wave_a_next = mode[2] ? ~wave_a_reg : wave_a_reg;
          end else begin
            wave_a_next = apply_act(act_a, wave_a_reg);
          end
        end
        if (match_now[1] && !block_reg && !at_top && act_b[1]) begin
          wave_b_next = apply_act(act_b, wave_b_reg);
        end
        if (at_top) begin
          // Restart level; compare zero then spikes for one tick
          if (act_a[1]) begin
            wave_a_next = ~act_a[0];
          end
          if (act_b[1]) begin
            wave_b_next = ~act_b[0];
          end
        end
      end else begin
        if (match_now[0] && !block_reg) begin
          wave_a_next = apply_act(act_a, wave_a_reg);
        end
        if (match_now[1] && !block_reg) begin
          wave_b_next = apply_act(act_b, wave_b_reg);
        end
      end
    end
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    case (1'b1)
      hit(paddr, `TMR_A_CTRL): rdata_next[`TMR_CTRL_W-1:0] = ctrl_reg;
      hit(paddr, `TMR_A_COUNT): rdata_next[7:0] = count_reg;
      hit(paddr, `TMR_A_CMPA): rdata_next[7:0] = cmpa_buf_reg;
      hit(paddr, `TMR_A_CMPB): rdata_next[7:0] = cmpb_buf_reg;
      hit(paddr, `TMR_A_FLAGS): rdata_next[2:0] = flag_reg;
      hit(paddr, `TMR_A_DIR): rdata_next[1:0] = dir_reg;
      hit(paddr, `TMR_A_EVENT): rdata_next[1:0] = {wave_b_reg, wave_a_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is taken at the access edge and stands while pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= acc;
      pslverr <= 1'b0;
      if (acc && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {`TMR_CTRL_W{1'b0}};
      count_reg <= `TMR_ZERO;
      cmpa_buf_reg <= `TMR_ZERO;
      cmpb_buf_reg <= `TMR_ZERO;
      cmpa_act_reg <= `TMR_ZERO;
      cmpb_act_reg <= `TMR_ZERO;
      flag_reg <= 3'h0;
      dir_reg <= 2'h0;
      match_reg <= 2'h0;
      block_reg <= 1'b0;
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[`TMR_CTRL_W-1:0];
      end
      if (wr_dir) begin
        dir_reg <= pwdata[1:0];
      end
      if (wr_cmpa) begin
        cmpa_buf_reg <= pwdata[7:0];
      end
      if (wr_cmpb) begin
        cmpb_buf_reg <= pwdata[7:0];
      end
      // Direct in non-pwm modes; pwm loads at top to keep pulses whole
      if (!is_pwm) begin
        cmpa_act_reg <= wr_cmpa ? pwdata[7:0] : cmpa_buf_reg;
        cmpb_act_reg <= wr_cmpb ? pwdata[7:0] : cmpb_buf_reg;
      end else if (tick && at_top) begin
        cmpa_act_reg <= cmpa_buf_reg;
        cmpb_act_reg <= cmpb_buf_reg;
      end
      count_reg <= count_next;
      flag_reg <= flag_next;
      wave_a_reg <= wave_a_next;
      wave_b_reg <= wave_b_next;
      if (tick) begin
        match_reg <= match_now & {2{~block_reg}};
        block_reg <= 1'b0;
      end
      if (wr_count) begin
        // A count write masks matches on the next tick
        block_reg <= 1'b1;
      end
    end
  end

  // Pins and flags leave through flops loaded from the next state, in step with the state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_pin_a <= 1'b0;
      wave_pin_b <= 1'b0;
      wave_oe_a <= 1'b0;
      wave_oe_b <= 1'b0;
      overflow_flag_out <= 1'b0;
      compare_a_flag_out <= 1'b0;
      compare_b_flag_out <= 1'b0;
    end else if (clk_en) begin
      wave_pin_a <= wave_a_next & dir_reg[0] & pin_link(act_a, is_pwm, mode[`TMR_MODE_BIT_TWO]);
      wave_pin_b <= wave_b_next & dir_reg[1] & pin_link(act_b, is_pwm, 1'b0);
      wave_oe_a <= dir_reg[0];
      wave_oe_b <= dir_reg[1];
      overflow_flag_out <= flag_next[`TMR_F_OVF];
      compare_a_flag_out <= flag_next[`TMR_F_CMPA];
      compare_b_flag_out <= flag_next[`TMR_F_CMPB];
    end
  end
endmodule
`default_nettype wire

// file: tmr_defines.vh
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
`define TMR_A_CTRL 12'h000
`define TMR_A_COUNT 12'h004
`define TMR_A_CMPA 12'h008
`define TMR_A_CMPB 12'h00C
`define TMR_A_FLAGS 12'h010
`define TMR_A_DIR 12'h014
`define TMR_A_EVENT 12'h018
`define TMR_MODE_NORMAL 3'h0
`define TMR_MODE_CTC 3'h2
`define TMR_MODE_FPWM_FF 3'h3
`define TMR_MODE_FPWM_A 3'h7
`define TMR_MODE_BIT_TWO 2
`define TMR_ACT_OFF 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3
`define TMR_MAX 8'hFF
`define TMR_ZERO 8'h00
`define TMR_F_OVF 0
`define TMR_F_CMPA 1
`define TMR_F_CMPB 2
`define TMR_C_MODE_LO 0
`define TMR_C_MODE_HI 2
`define TMR_C_CLK_LO 4
`define TMR_C_CLK_HI 6
`define TMR_C_ACTB_LO 8
`define TMR_C_ACTB_HI 9
`define TMR_C_ACTA_LO 10
`define TMR_C_ACTA_HI 11
`define TMR_CTRL_W 12
`endif

// file: tmr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic ovf_int_ack,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic wave_pin_a,
  input wire logic wave_pin_b,
  input wire logic wave_oe_a,
  input wire logic wave_oe_b,
  input wire logic overflow_flag_out,
  input wire logic compare_a_flag_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Two quiet cycles, so no tick can set the flag again
  sequence s_ack_quiet;
    ovf_int_ack && clk_en && !timer_tick ##1 clk_en && !timer_tick;
  endsequence
  chk_ovf_ack_clear: assert property (s_ack_quiet |=> !overflow_flag_out)
    else $error("overflow flag stayed after ack");
  chk_ovf_on_tick: assert property ($rose(overflow_flag_out) && $past(clk_en) |-> $past(timer_tick))
    else $error("overflow flag rose without tick");
  chk_cmpa_on_tick: assert property ($rose(compare_a_flag_out) && $past(clk_en) |-> $past(timer_tick))
    else $error("compare flag rose without tick");
  chk_pin_a_dir: assert property (!wave_oe_a |-> !wave_pin_a)
    else $error("pin a driven while input");
  chk_pin_b_dir: assert property (!wave_oe_b |-> !wave_pin_b)
    else $error("pin b driven while input");
  chk_freeze_hold: assert property (!clk_en |=> $stable(wave_pin_a) && $stable(overflow_flag_out))
    else $error("state moved while frozen");
  chk_ready_latency: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("pready late");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held two cycles");
endmodule
bind tmr_core tmr_properties tmr_properties_inst (.*);
`default_nettype wire

// file: tb_tmr_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.vh"
module tb_tmr_core;
  logic pclk = 0, presetn = 0, clk_en = 1, timer_tick = 0, ovf_int_ack = 0;
  logic cmpa_int_ack = 0, cmpb_int_ack = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, wave_pin_a, wave_pin_b, wave_oe_a, wave_oe_b;
  wire overflow_flag_out, compare_a_flag_out, compare_b_flag_out;
  int errors = 0, tests_run = 0, cyc = 0, n;
  logic [15:0] lf = 16'hF647;
  logic [8:0] sm;
  logic [7:0] s, top;
  logic [2:0] m;
  logic [1:0] act;
  logic [2:0] rsv [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  tmr_core tmr_core_inst (.*);
  initial forever #2 pclk = ~pclk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Count after k ticks; bit 8 marks a pass through zero
  function automatic logic [8:0] adv(input logic [7:0] v, input int k);
    return 9'(v + k);
  endfunction
  function automatic logic [31:0] ctl(input logic [2:0] md, input logic [1:0] ac);
    return {20'h0, ac, ac, 1'b0, 3'h1, 1'b0, md};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t == 20) begin
      errors++;
      test_done();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic tick(input int k);
    @(posedge pclk);
    timer_tick <= 1;
    repeat (k) @(posedge pclk);
    timer_tick <= 0;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, `TMR_A_CTRL, 0);
    chk("ctrl reset", 0, rd);
    apb(1, 12'h01C, 32'hFFFFFFFF);
    apb(0, 12'h01C, 0);
    chk("unmapped", 0, rd);
    chk("slverr", 0, pslverr);
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      s = (i == 0) ? 8'hFF : lf[7:0];
      n = (i == 0) ? 1 : lf[15:8] + 1;
      apb(1, `TMR_A_CTRL, ctl(rsv[i % 5], 0));
      apb(1, `TMR_A_COUNT, s);
      apb(1, `TMR_A_FLAGS, 7);
      tick(n);
      sm = adv(s, n);
      apb(0, `TMR_A_COUNT, 0);
      chk("count", sm[7:0], rd);
      apb(0, `TMR_A_FLAGS, 0);
      chk("overflow", sm[8], rd[0]);
    end
    apb(1, `TMR_A_FLAGS, 1);
    apb(0, `TMR_A_FLAGS, 0);
    chk("flag w1c", 0, rd[0]);
    tick(256);
    @(posedge pclk);
    {ovf_int_ack, cmpa_int_ack, cmpb_int_ack} <= 3'h7;
    @(posedge pclk);
    {ovf_int_ack, cmpa_int_ack, cmpb_int_ack} <= 3'h0;
    apb(0, `TMR_A_FLAGS, 0);
    chk("flag ack", 0, rd[2:0]);
    $display("test normal done");
    apb(1, `TMR_A_CTRL, ctl(0, 0) & 32'hFFFFFF8F);
    apb(1, `TMR_A_COUNT, 8'h33);
    tick(5);
    apb(1, `TMR_A_CTRL, ctl(0, 0));
    clk_en <= 0;
    tick(5);
    clk_en <= 1;
    apb(0, `TMR_A_COUNT, 0);
    chk("stopped", 8'h33, rd);
    $display("test stop done");
    apb(1, `TMR_A_CTRL, ctl(`TMR_MODE_CTC, `TMR_ACT_TOGGLE));
    apb(1, `TMR_A_CMPA, 5);
    apb(1, `TMR_A_DIR, 1);
    apb(1, `TMR_A_COUNT, 0);
    apb(1, `TMR_A_FLAGS, 7);
    tick(8);
    apb(0, `TMR_A_COUNT, 0);
    chk("ctc count", 2, rd);
    chk("ctc toggle", 1, wave_pin_a);
    apb(0, `TMR_A_FLAGS, 0);
    chk("ctc flags", 2'h2, rd[1:0]);
    chk("cmpa out", 1, compare_a_flag_out);
    chk("cmpb out", 1, compare_b_flag_out);
    chk("ovf out", 0, overflow_flag_out);
    apb(1, `TMR_A_COUNT, 8'h10);
    apb(1, `TMR_A_FLAGS, 7);
    tick(8'hF0);
    apb(0, `TMR_A_FLAGS, 0);
    chk("ctc missed top", 2'h1, rd[1:0]);
    apb(1, `TMR_A_DIR, 0);
    repeat (2) @(negedge pclk);
    chk("pin off", 0, {wave_oe_a, wave_pin_a});
    $display("test ctc done");
    for (int k = 0; k < 4; k++) begin
      m = k[1] ? `TMR_MODE_FPWM_A : `TMR_MODE_FPWM_FF;
      act = k[0] ? `TMR_ACT_SET : `TMR_ACT_CLEAR;
      top = k[1] ? 8'hC0 : `TMR_MAX;
      apb(1, `TMR_A_CTRL, ctl(m, act));
      apb(1, `TMR_A_CMPA, 8'hC0);
      apb(1, `TMR_A_CMPB, 8'h40);
      apb(1, `TMR_A_DIR, 3);
      apb(1, `TMR_A_COUNT, top - 8'h07);
      apb(1, `TMR_A_FLAGS, 7);
      tick(8);
      apb(0, `TMR_A_COUNT, 0);
      chk("pwm restart", 0, rd);
      apb(0, `TMR_A_FLAGS, 0);
      chk("pwm overflow", 1, rd[0]);
      chk("pwm b start", act == 2, wave_pin_b);
      chk("pwm oe b", 1, wave_oe_b);
      tick(8'h50);
      chk("pwm b match", act == 3, wave_pin_b);
      apb(1, `TMR_A_CMPA, 8'h48);
      tick(8);
      apb(0, `TMR_A_COUNT, 0);
      chk("pwm count", 8'h58, rd);
      chk("pwm a buffered", act == 2, wave_pin_a);
    end
    $display("test pwm done");
    test_done();
  end
endmodule
`default_nettype wire
